// File: nfc_consts.svh
// Constants of the NAND flash host controller
`ifndef NFC_CONSTS_SVH
`define NFC_CONSTS_SVH
`define NFC_CMD_READ_SETUP   8'h00
`define NFC_CMD_READ_CONF    8'h30
`define NFC_CMD_CPBK_READ    8'h35
`define NFC_CMD_READ_ID      8'h90
`define NFC_CMD_RESET        8'hFF
`define NFC_CMD_PROG_SETUP   8'h80
`define NFC_CMD_PROG_CONF    8'h10
`define NFC_CMD_CACHE_CONF   8'h15
`define NFC_CMD_CPBK_PROG    8'h85
`define NFC_CMD_ERASE_SETUP  8'h60
`define NFC_CMD_ERASE_CONF   8'hD0
`define NFC_CMD_RAND_IN      8'h85
`define NFC_CMD_RAND_OUT     8'h05
`define NFC_CMD_RAND_OUT_C   8'hE0
`define NFC_CMD_STATUS       8'h70
`define NFC_ADDR_BITS_X8     28
`define NFC_ADDR_BITS_X16    27
`define NFC_COL_BITS_X8      12
`define NFC_COL_BITS_X16     11
`define NFC_PAGE_BYTES_X8    2112
`define NFC_PAGE_WORDS_X16   1056
`define NFC_PAGES            65536
`define NFC_BLOCKS           1024
`define NFC_STROBE_LOW_CYC   2
`define NFC_STROBE_HIGH_CYC  2
`endif

// File: nfc_pkg.sv
// Types of the NAND flash host controller
package nfc_pkg;
   typedef enum logic [2:0] {
      NFC_OP_RESET  = 3'h0,
      NFC_OP_STATUS = 3'h1,
      NFC_OP_ID     = 3'h2,
      NFC_OP_READ   = 3'h3,
      NFC_OP_PROG   = 3'h4,
      NFC_OP_ERASE  = 3'h5,
      NFC_OP_CACHE  = 3'h6,
      NFC_OP_CPBK   = 3'h7
   } nfc_op_t;

   typedef enum logic [7:0] {
      NFC_IDLE   = 8'h01,
      NFC_CMD1   = 8'h02,
      NFC_ADDR   = 8'h04,
      NFC_WDATA  = 8'h08,
      NFC_CMD2   = 8'h10,
      NFC_WAIT   = 8'h20,
      NFC_RDATA  = 8'h40,
      NFC_DONE   = 8'h80
   } nfc_state_t;
endpackage

// File: nfc_fifo.sv
// Parameterised valid/ready FIFO in flip-flops
`timescale 1ns/10ps
module nfc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   // ----------------------------------------
   // Pointers and storage
   // ----------------------------------------
   always_comb begin
      in_ready  = (cnt_q != (AW+1)'(DEPTH));
      out_valid = (cnt_q != '0);
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      out_data  = mem_q[rd_q];
      mem_d     = mem_q;
      wr_d      = wr_q;
      rd_d      = rd_q;
      cnt_d     = cnt_q;
      if (push) begin
         mem_d[wr_q] = in_data;
         wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
      mem_q <= mem_d;
   end
endmodule

// File: nfc_host.sv
// Host-side controller driving the NAND flash command, address and data pins
//
// Operation
// RULE1: Four address cycles: two column, two row
// RULE2: Unused address bits and upper lanes driven low
// RULE3: Device ignores surplus address cycles
// RULE4: 65,536 pages of 2112 bytes/1056 words
// RULE5: Device chains data and cache registers
// RULE6: Page read/program, block erase, 1024 blocks
// RULE7: Commands and addresses on low eight lines
// RULE8: Write strobe pulsed low with chip select low
// RULE9: Latch strobes select command, address or data
// RULE10: Reset, status, identifier are single-cycle commands
// RULE11: Read, program, erase use setup then confirm
// RULE12: Erase takes only two row cycles
// RULE13: Busy device takes only reset, status
// RULE14: Cache program loads cache during programming
// RULE15: Copy-back: read 00h/35h, program 85h/10h; code never issues 35h, its copy-back op sends only 85h/10h
// RULE16: Random data in/out stays within page
// RULE17: Never issue undefined command codes
// RULE18: Device auto-reads first page after power-on
// RULE19: Ready/busy low during operation
// RULE20: Read strobe fall gives next data item
// RULE21: Device ignores chip select high while busy
// RULE22: Auto-read enabled only by tied-high input
// RULE23: Wait for ready before other commands
// RULE24: Latch strobes low in data, never both
`timescale 1ns/10ps
`include "nfc_consts.svh"
module nfc_host #(
   parameter int IO_W  = 16,
   parameter int DEPTH = 8,
   parameter int LEN_W = 12
) (
   input  wire logic                clk,
   input  wire logic                srst,
   input  wire logic                word_org,
   input  wire logic                req_valid,
   output logic                     req_ready,
   input  wire logic [2:0]          req_op,
   input  wire logic [27:0]         req_addr,
   input  wire logic [LEN_W-1:0]    req_len,
   input  wire logic                wr_valid,
   output logic                     wr_ready,
   input  wire logic [IO_W-1:0]     wr_data,
   output logic                     rd_valid,
   input  wire logic                rd_ready,
   output logic [IO_W-1:0]          rd_data,
   output logic                     done,
   output logic                     chip_sel_n,
   output logic                     cmd_latch,
   output logic                     addr_latch,
   output logic                     write_strobe_n,
   output logic                     read_strobe_n,
   output logic [IO_W-1:0]          io_out,
   output logic                     io_oe_n,
   input  wire logic [IO_W-1:0]     io_in,
   input  wire logic                ready_busy
);
   nfc_pkg::nfc_state_t st_q, st_d;
   nfc_pkg::nfc_op_t    op_q, op_d;
   logic [27:0]      addr_q, addr_d;
   logic [LEN_W-1:0] len_q, len_d;
   logic [1:0]       acnt_q, acnt_d;
   logic [1:0]       tcnt_q, tcnt_d;
   logic             ph_q, ph_d;
   logic             worg_q, worg_d;
   logic [IO_W-1:0]  io_q, io_d;
   logic             we_q, we_d, re_q, re_d, cle_q, cle_d, ale_q, ale_d, ce_q, ce_d;
   logic             oe_q, oe_d;
   logic [IO_W-1:0]  rdat_q, rdat_d;
   logic             cap_q, cap_d;
   logic             rb_seen_q, rb_seen_d;
   logic             fin_valid, fin_ready, fout_valid, fout_ready;
   logic [IO_W-1:0]  fout_data;
   logic [7:0]       acyc;
   logic             tick;

   // ----------------------------------------
   // Read data buffer
   // ----------------------------------------
   nfc_fifo #(.WIDTH(IO_W), .DEPTH(DEPTH)) u_rd_fifo (
      .clk       (clk),
      .srst      (srst),
      .in_valid  (fin_valid),
      .in_ready  (fin_ready),
      .in_data   (rdat_q),
      .out_valid (fout_valid),
      .out_ready (fout_ready),
      .out_data  (fout_data)
   );
   assign fin_valid  = cap_q;
   assign rd_valid   = fout_valid;
   assign fout_ready = rd_ready;
   assign rd_data    = fout_data;

   assign chip_sel_n     = ce_q;
   assign cmd_latch      = cle_q;
   assign addr_latch     = ale_q;
   assign write_strobe_n = we_q;
   assign read_strobe_n  = re_q;
   assign io_out         = io_q;
   assign io_oe_n        = oe_q;
   assign req_ready      = (st_q == nfc_pkg::NFC_IDLE);
   assign wr_ready       = (st_q == nfc_pkg::NFC_WDATA) && !ph_q && tcnt_q == 2'h0;

   // ----------------------------------------
   // Address cycle byte
   // ----------------------------------------
   always_comb begin
      acyc = 8'h00;
      // RULE1: column then row
      unique case (acnt_q)
         // RULE16: column start within page
         2'h0: acyc = addr_q[7:0];
         // RULE2: unused column bits low
         2'h1: acyc = worg_q ? {5'h00, addr_q[10:8]} : {4'h0, addr_q[11:8]};
         2'h2: acyc = worg_q ? addr_q[18:11] : addr_q[19:12];
         2'h3: acyc = worg_q ? addr_q[26:19] : addr_q[27:20];
      endcase
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      st_d = st_q; op_d = op_q; addr_d = addr_q; len_d = len_q;
      acnt_d = acnt_q; ph_d = ph_q; worg_d = worg_q;
      io_d = io_q; we_d = 1'b1; re_d = 1'b1; cle_d = cle_q; ale_d = ale_q;
      ce_d = ce_q; oe_d = oe_q; rdat_d = rdat_q; cap_d = 1'b0;
      rb_seen_d = rb_seen_q; done = 1'b0;
      tick = (tcnt_q == 2'h0);
      tcnt_d = tick ? 2'h0 : tcnt_q - 2'h1;
      unique case (st_q)
         nfc_pkg::NFC_IDLE: begin
            ce_d = 1'b1; cle_d = 1'b0; ale_d = 1'b0; oe_d = 1'b1;
            // RULE23: only start when ready
            if (req_valid && ready_busy) begin
               op_d = nfc_pkg::nfc_op_t'(req_op);
               addr_d = req_addr; len_d = req_len; worg_d = word_org;
               acnt_d = (req_op == 3'(nfc_pkg::NFC_OP_ERASE)) ? 2'h2 : 2'h0;
               ph_d = 1'b0; ce_d = 1'b0; st_d = nfc_pkg::NFC_CMD1;
            end
         end
         nfc_pkg::NFC_CMD1, nfc_pkg::NFC_CMD2: begin
            // RULE9: command cycle, RULE24: one latch only
            cle_d = 1'b1; ale_d = 1'b0; oe_d = 1'b0;
            // RULE17: only defined codes, RULE10: RULE11: setup/confirm
            if (st_q == nfc_pkg::NFC_CMD1) begin
               unique case (op_q)
                  nfc_pkg::NFC_OP_RESET:  io_d = IO_W'(`NFC_CMD_RESET);
                  nfc_pkg::NFC_OP_STATUS: io_d = IO_W'(`NFC_CMD_STATUS);
                  nfc_pkg::NFC_OP_ID:     io_d = IO_W'(`NFC_CMD_READ_ID);
                  nfc_pkg::NFC_OP_ERASE:  io_d = IO_W'(`NFC_CMD_ERASE_SETUP);
                  nfc_pkg::NFC_OP_CPBK:   io_d = IO_W'(`NFC_CMD_CPBK_PROG);
                  nfc_pkg::NFC_OP_PROG, nfc_pkg::NFC_OP_CACHE:
                     io_d = IO_W'(`NFC_CMD_PROG_SETUP);
                  default:                io_d = IO_W'(`NFC_CMD_READ_SETUP);
               endcase
            end else begin
               unique case (op_q)
                  nfc_pkg::NFC_OP_ERASE:  io_d = IO_W'(`NFC_CMD_ERASE_CONF);
                  nfc_pkg::NFC_OP_CACHE:  io_d = IO_W'(`NFC_CMD_CACHE_CONF);
                  nfc_pkg::NFC_OP_READ:   io_d = IO_W'(`NFC_CMD_READ_CONF);
                  default:                io_d = IO_W'(`NFC_CMD_PROG_CONF);
               endcase
            end
            // RULE8: strobe low then rising edge
            if (tick) begin
               if (!ph_q) begin
                  ph_d = 1'b1; tcnt_d = 2'(`NFC_STROBE_LOW_CYC - 1);
               end else begin
                  ph_d = 1'b0; tcnt_d = 2'(`NFC_STROBE_HIGH_CYC - 1);
                  if (st_q == nfc_pkg::NFC_CMD2) begin
                     st_d = nfc_pkg::NFC_WAIT; rb_seen_d = 1'b0;
                  end else if (op_q == nfc_pkg::NFC_OP_RESET) begin
                     st_d = nfc_pkg::NFC_WAIT; rb_seen_d = 1'b0;
                  end else if (op_q == nfc_pkg::NFC_OP_STATUS) begin
                     st_d = nfc_pkg::NFC_RDATA; len_d = LEN_W'(1);
                  end else begin
                     st_d = nfc_pkg::NFC_ADDR;
                  end
               end
            end
            we_d = !(ph_d && !tick) && !(tick && !ph_q);
         end
         nfc_pkg::NFC_ADDR: begin
            cle_d = 1'b0; ale_d = 1'b1; oe_d = 1'b0;
            // RULE7: address on low lane only
            io_d = IO_W'(acyc);
            if (tick) begin
               if (!ph_q) begin
                  ph_d = 1'b1; tcnt_d = 2'(`NFC_STROBE_LOW_CYC - 1);
               end else begin
                  ph_d = 1'b0; tcnt_d = 2'(`NFC_STROBE_HIGH_CYC - 1);
                  acnt_d = acnt_q + 2'h1;
                  // RULE12: identifier takes one cycle, erase two
                  if (op_q == nfc_pkg::NFC_OP_ID || acnt_q == 2'h3) begin
                     // Address latch held through strobe rise
                     unique case (op_q)
                        nfc_pkg::NFC_OP_ID:    st_d = nfc_pkg::NFC_RDATA;
                        nfc_pkg::NFC_OP_ERASE: st_d = nfc_pkg::NFC_CMD2;
                        nfc_pkg::NFC_OP_READ:  st_d = nfc_pkg::NFC_CMD2;
                        default:               st_d = nfc_pkg::NFC_WDATA;
                     endcase
                     if (op_q == nfc_pkg::NFC_OP_CPBK && len_q == '0) begin
                        st_d = nfc_pkg::NFC_CMD2;
                     end
                  end
               end
            end
            we_d = !(ph_d && !tick) && !(tick && !ph_q);
            if (op_q == nfc_pkg::NFC_OP_ID) begin
               io_d = '0;
            end
         end
         nfc_pkg::NFC_WDATA: begin
            // RULE24: latches low for data
            cle_d = 1'b0; ale_d = 1'b0; oe_d = 1'b0;
            if (tick && !ph_q && wr_valid) begin
               io_d = worg_q ? wr_data : {{(IO_W-8){1'b0}}, wr_data[7:0]};
               ph_d = 1'b1; tcnt_d = 2'(`NFC_STROBE_LOW_CYC - 1);
            end else if (tick && ph_q) begin
               ph_d = 1'b0; tcnt_d = 2'(`NFC_STROBE_HIGH_CYC - 1);
               len_d = len_q - 1'b1;
               if (len_q == LEN_W'(1)) begin
                  st_d = nfc_pkg::NFC_CMD2;
               end
            end
            we_d = !(ph_d && !tick) && !(tick && ph_d && !ph_q);
         end
         nfc_pkg::NFC_WAIT: begin
            // RULE19: wait for busy then ready
            oe_d = 1'b1; cle_d = 1'b0;
            if (!ready_busy) begin
               rb_seen_d = 1'b1;
            end
            if ((rb_seen_q || tick) && ready_busy && tcnt_q == 2'h0 && rb_seen_q) begin
               st_d = (op_q == nfc_pkg::NFC_OP_READ) ? nfc_pkg::NFC_RDATA
                                                     : nfc_pkg::NFC_DONE;
            end
         end
         nfc_pkg::NFC_RDATA: begin
            // RULE20: read strobe fall per item
            oe_d = 1'b1; cle_d = 1'b0; ale_d = 1'b0;
            if (len_q == '0) begin
               st_d = nfc_pkg::NFC_DONE;
            end else if (tick && !ph_q && fin_ready) begin
               ph_d = 1'b1; tcnt_d = 2'(`NFC_STROBE_LOW_CYC - 1);
            end else if (tick && ph_q) begin
               rdat_d = worg_q ? io_in : {{(IO_W-8){1'b0}}, io_in[7:0]};
               cap_d = 1'b1; ph_d = 1'b0;
               tcnt_d = 2'(`NFC_STROBE_HIGH_CYC - 1);
               len_d = len_q - 1'b1;
            end
            re_d = !(ph_d && !(tick && ph_q));
         end
         nfc_pkg::NFC_DONE: begin
            done = 1'b1; ce_d = 1'b1; oe_d = 1'b1; st_d = nfc_pkg::NFC_IDLE;
         end
         default: st_d = nfc_pkg::NFC_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= nfc_pkg::NFC_IDLE; op_q <= nfc_pkg::NFC_OP_RESET;
         addr_q <= '0; len_q <= '0; acnt_q <= 2'h0; tcnt_q <= 2'h0;
         ph_q <= 1'b0; worg_q <= 1'b0; io_q <= '0;
         we_q <= 1'b1; re_q <= 1'b1; cle_q <= 1'b0; ale_q <= 1'b0;
         ce_q <= 1'b1; oe_q <= 1'b1; rdat_q <= '0; cap_q <= 1'b0;
         rb_seen_q <= 1'b0;
      end else begin
         st_q <= st_d; op_q <= op_d; addr_q <= addr_d; len_q <= len_d;
         acnt_q <= acnt_d; tcnt_q <= tcnt_d; ph_q <= ph_d; worg_q <= worg_d;
         io_q <= io_d; we_q <= we_d; re_q <= re_d; cle_q <= cle_d;
         ale_q <= ale_d; ce_q <= ce_d; oe_q <= oe_d; rdat_q <= rdat_d;
         cap_q <= cap_d; rb_seen_q <= rb_seen_d;
      end
   end
endmodule

// File: nfc_host_assertions.sv
// Pin-level assertions for the NAND flash host controller
`timescale 1ns/10ps
module nfc_host_assertions #(
   parameter int IO_W = 16
) (
   input wire logic            clk,
   input wire logic            srst,
   input wire logic            done,
   input wire logic            chip_sel_n,
   input wire logic            cmd_latch,
   input wire logic            addr_latch,
   input wire logic            write_strobe_n,
   input wire logic            read_strobe_n,
   input wire logic [IO_W-1:0] io_out,
   input wire logic            io_oe_n,
   input wire logic            ready_busy
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // ---------------------------------------------
   // Strobe shape
   // ---------------------------------------------
   sequence s_wr_pulse;
      !write_strobe_n [*2] ##1 write_strobe_n;
   endsequence

   a_wr_width: assert property ($fell(write_strobe_n) |-> s_wr_pulse)
      else $error("write strobe pulse width wrong");
   a_wr_select: assert property (!write_strobe_n |-> !chip_sel_n)
      else $error("write strobe without chip select");
   a_wr_drive: assert property (!write_strobe_n |-> !io_oe_n && read_strobe_n)
      else $error("bus not driven during write");
   a_latch_excl: assert property (!(cmd_latch && addr_latch))
      else $error("both latch strobes high");
   a_rd_quiet: assert property (!read_strobe_n |-> !cmd_latch && !addr_latch && io_oe_n)
      else $error("read cycle with latch or drive");

   // ---------------------------------------------
   // Command and address content, done pulse
   // ---------------------------------------------
   a_lane_low: assert property (!write_strobe_n && (cmd_latch || addr_latch) |-> io_out[IO_W-1:8] == '0)
      else $error("upper lanes not low");
   a_cmd_defined: assert property (!write_strobe_n && cmd_latch |-> io_out[7:0] inside
      {8'h00, 8'h30, 8'h35, 8'h90, 8'hFF, 8'h80, 8'h10, 8'h15, 8'h85, 8'h60, 8'hD0, 8'h05, 8'hE0,
       8'h70})
      else $error("undefined command code");
   a_busy_cmds: assert property (!write_strobe_n && cmd_latch && !ready_busy |-> io_out[7:0] inside {8'hFF, 8'h70})
      else $error("command other than reset or status while busy");
   a_busy_quiet: assert property (!write_strobe_n && !ready_busy |-> cmd_latch)
      else $error("address or data while busy");
   a_done_pulse: assert property (done |-> ready_busy ##1 !done)
      else $error("done while busy or too long");
endmodule

bind nfc_host nfc_host_assertions #(.IO_W(IO_W)) u_chk (
   .clk(clk), .srst(srst), .done(done), .chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch),
   .addr_latch(addr_latch), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
   .io_out(io_out), .io_oe_n(io_oe_n), .ready_busy(ready_busy));

// File: nfc_flash_model.sv
// Behavioural flash device answering the host pins
`timescale 1ns/10ps
module nfc_flash_model #(
   parameter int          BUSY_CYC = 20,
   parameter logic [15:0] ID_VAL   = 16'h005A, // Arbitrary identifier value
   parameter logic [15:0] ST_VAL   = 16'h00E0
) (
   input  wire logic        clk,
   input  wire logic        chip_sel_n,
   input  wire logic        cmd_latch,
   input  wire logic        addr_latch,
   input  wire logic        write_strobe_n,
   input  wire logic        read_strobe_n,
   input  wire logic        io_oe_n,
   input  wire logic [15:0] io_out,
   output logic [15:0]      io_in,
   output logic             ready_busy
);
   logic [17:0] logq[$];
   logic [15:0] pg[0:63];
   logic [15:0] dout = 16'h0000;
   logic [7:0]  cmd  = 8'h00;
   int          acnt = 0;
   int          col  = 0;
   int          bcnt = 0;

   always @(posedge clk) begin
      if (bcnt > 0) begin
         bcnt = bcnt - 1;
      end
   end
   assign ready_busy = (bcnt == 0);

   always @(posedge write_strobe_n) begin
      if (!chip_sel_n && cmd_latch) begin
         logq.push_back({2'h2, io_out});
         if (bcnt == 0 || io_out[7:0] inside {8'hFF, 8'h70}) begin
            cmd = io_out[7:0];
            acnt = 0;
            if (cmd inside {8'h30, 8'h35, 8'h10, 8'h15, 8'hD0, 8'hFF}) begin
               bcnt = BUSY_CYC;
            end
         end
      end else if (!chip_sel_n && addr_latch) begin
         logq.push_back({2'h1, io_out});
         if (acnt == 0 && cmd != 8'h60) begin
            col = io_out[5:0];
         end
         acnt++;
      end else if (!chip_sel_n) begin
         logq.push_back({2'h0, io_out});
         pg[col] = io_out;
         col = (col + 1) % 64;
      end
   end

   // Next item on read strobe fall
   always @(negedge read_strobe_n) begin
      if (!chip_sel_n) begin
         if (cmd == 8'h70) begin
            dout = ST_VAL;
         end else if (cmd == 8'h90) begin
            dout = ID_VAL;
         end else begin
            dout = pg[col];
            col = (col + 1) % 64;
         end
      end
   end
   assign io_in = (!chip_sel_n && !read_strobe_n && io_oe_n) ? dout : ~dout;
endmodule

// File: nfc_host_tb.sv
// Self-checking bench for the NAND flash host controller
`timescale 1ns/10ps
module nfc_host_tb;
   logic        clk;
   logic        srst;
   logic        word_org;
   logic        req_valid;
   logic        req_ready;
   logic [2:0]  req_op;
   logic [27:0] req_addr;
   logic [11:0] req_len;
   logic        wr_valid;
   logic        wr_ready;
   logic [15:0] wr_data;
   logic        rd_valid;
   logic        rd_ready;
   logic [15:0] rd_data;
   logic        done;
   logic        chip_sel_n;
   logic        cmd_latch;
   logic        addr_latch;
   logic        write_strobe_n;
   logic        read_strobe_n;
   logic [15:0] io_out;
   logic        io_oe_n;
   logic [15:0] io_in;
   logic        ready_busy;
   logic [17:0] exp_q[$];
   int          num_errors;
   int          checked;
   int          cyc;
   localparam logic [27:0] A8  = 28'hABCDE12;
   localparam logic [27:0] A16 = {1'b0, 16'hC35A, 11'h7FF};

   nfc_host dut (.clk(clk), .srst(srst), .word_org(word_org), .req_valid(req_valid),
      .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_len(req_len),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_data(rd_data), .done(done), .chip_sel_n(chip_sel_n),
      .cmd_latch(cmd_latch), .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
      .read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in),
      .ready_busy(ready_busy));
   nfc_flash_model fm (.clk(clk), .chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch),
      .addr_latch(addr_latch), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
      .io_oe_n(io_oe_n), .io_out(io_out), .io_in(io_in), .ready_busy(ready_busy));

   // ---------------------------------------------
   // Clock, timeout, verdict
   // ---------------------------------------------
   initial clk = 1'b0;
   always #20 clk = ~clk;

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         $display("CHECK FAILED %0t timeout", $time);
         num_errors++;
         give_verdict;
      end
   end

   task automatic give_verdict;
      $display("Errors %0d, checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ---------------------------------------------
   // Shared helpers
   // ---------------------------------------------
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic ex(input logic [1:0] k, input logic [7:0] b);
      exp_q.push_back({k, 8'h00, b});
   endtask

   task automatic chk_log;
      chk(18'(fm.logq.size()), 18'(exp_q.size()));
      foreach (exp_q[i]) begin
         if (i < fm.logq.size()) begin
            chk(fm.logq[i], exp_q[i]);
         end
      end
      exp_q.delete();
      fm.logq.delete();
   endtask

   task automatic issue(input logic [2:0] op, input logic [27:0] a, input logic [11:0] n,
                        input logic org);
      int t = 0;
      req_valid <= 1'b1;
      req_op <= op;
      req_addr <= a;
      req_len <= n;
      word_org <= org;
      do @(posedge clk); while (!(req_ready === 1'b1 && ready_busy === 1'b1) && ++t < 2000);
      req_valid <= 1'b0;
      t = 0;
      do @(posedge clk); while (done !== 1'b1 && ++t < 5000);
      chk({17'h0, done}, 18'h1);
   endtask

   task automatic send(input int n);
      for (int i = 0; i < n; i++) begin
         wr_valid <= 1'b1;
         wr_data <= {8'hA5, 8'(8'h30 + i)};
         do @(posedge clk); while (wr_ready !== 1'b1);
      end
      wr_valid <= 1'b0;
   endtask

   task automatic drain(input int n, input logic [15:0] base, input logic inc);
      int k = 0;
      repeat (300) @(posedge clk);
      rd_ready <= 1'b1;
      while (k < n) begin
         @(posedge clk);
         if (rd_valid === 1'b1) begin
            chk({2'h0, rd_data}, {2'h0, base + (inc ? 16'(k) : 16'h0000)});
            k++;
         end
      end
      rd_ready <= 1'b0;
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_prog(input logic [2:0] op, input logic [7:0] conf);
      ex(2'h2, 8'h80);
      ex(2'h1, A8[7:0]);
      ex(2'h1, {4'h0, A8[11:8]});
      ex(2'h1, A8[19:12]);
      ex(2'h1, A8[27:20]);
      for (int i = 0; i < 10; i++) begin
         ex(2'h0, 8'(8'h30 + i));
      end
      ex(2'h2, conf);
      fork
         issue(op, A8, 12'h00A, 1'b0);
         send(10);
      join
      chk_log;
   endtask

   task automatic t_read;
      ex(2'h2, 8'h00);
      ex(2'h1, A8[7:0]);
      ex(2'h1, {4'h0, A8[11:8]});
      ex(2'h1, A8[19:12]);
      ex(2'h1, A8[27:20]);
      ex(2'h2, 8'h30);
      fork
         issue(3'h3, A8, 12'h00A, 1'b0);
         drain(10, 16'h0030, 1'b1);
      join
      chk_log;
   endtask

   task automatic t_id_status;
      ex(2'h2, 8'h90);
      ex(2'h1, 8'h00);
      fork
         issue(3'h2, A8, 12'h002, 1'b0);
         drain(2, 16'h005A, 1'b0);
      join
      chk_log;
      ex(2'h2, 8'h70);
      fork
         issue(3'h1, A8, 12'h001, 1'b0);
         drain(1, 16'h00E0, 1'b0);
      join
      chk_log;
   endtask

   task automatic t_word;
      ex(2'h2, 8'h60);
      ex(2'h1, 8'h5A);
      ex(2'h1, 8'hC3);
      ex(2'h2, 8'hD0);
      issue(3'h5, A16, 12'h000, 1'b1);
      chk_log;
      ex(2'h2, 8'h85);
      ex(2'h1, 8'hFF);
      ex(2'h1, 8'h07);
      ex(2'h1, 8'h5A);
      ex(2'h1, 8'hC3);
      ex(2'h2, 8'h10);
      issue(3'h7, A16, 12'h000, 1'b1);
      chk_log;
   endtask

   initial begin
      srst = 1'b1;
      word_org = 1'b0;
      req_valid = 1'b0;
      req_op = 3'h0;
      req_addr = 28'h0;
      req_len = 12'h0;
      wr_valid = 1'b0;
      wr_data = 16'h0;
      rd_ready = 1'b0;
      cyc = 0;
      num_errors = 0;
      checked = 0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      ex(2'h2, 8'hFF);
      issue(3'h0, 28'h0, 12'h000, 1'b0);
      chk_log;
      t_prog(3'h4, 8'h10);
      t_prog(3'h6, 8'h15);
      t_read;
      t_id_status;
      t_word;
      give_verdict;
   end
endmodule
